/* src/pgtm_top.sv */
// power-good tree mask registers and three power-good outputs
`timescale 1ns/1ps
`default_nettype none
module pgtm_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [5:0] buck_rail_good,
  input wire logic aux_regulator_2_good,
  input wire logic load_switch_a_good,
  input wire logic control_input_a,
  input wire logic control_input_b,
  input wire logic control_input_d,
  input wire logic control_input_e,
  input wire logic termination_regulator_good,
  input wire logic load_switch_b1_good,
  input wire logic load_switch_b2_good,
  input wire logic aux_regulator_3_good,
  output logic pg_output_1,
  output logic pg_output_2,
  output logic pg_output_4
);

  // ---------------------------------------------------------------
  // source synchronisers
  // ---------------------------------------------------------------
  logic [7:0] rail_raw;
  logic [7:0] pin_raw;
  logic [7:0] rail_meta_q;
  logic [7:0] rail_meta_d;
  logic [7:0] rail_sync_q;
  logic [7:0] rail_sync_d;
  logic [7:0] pin_meta_q;
  logic [7:0] pin_meta_d;
  logic [7:0] pin_sync_q;
  logic [7:0] pin_sync_d;

  // rails packed in first-mask order
  always_comb begin
    rail_raw = '0;
    rail_raw[pgtm_pkg::BIT_AUX2] = aux_regulator_2_good;
    rail_raw[pgtm_pkg::BIT_LSW_A] = load_switch_a_good;
    rail_raw[pgtm_pkg::BIT_BUCK_RAIL_1 +: pgtm_pkg::NUM_BUCK] = buck_rail_good;
  end

  // pins and lower rails packed in second-mask order
  always_comb begin
    pin_raw = '0;
    pin_raw[pgtm_pkg::BIT_CTL_E] = control_input_e;
    pin_raw[pgtm_pkg::BIT_CTL_D] = control_input_d;
    pin_raw[pgtm_pkg::BIT_CTL_B] = control_input_b;
    pin_raw[pgtm_pkg::BIT_CTL_A] = control_input_a;
    pin_raw[pgtm_pkg::BIT_TERM] = termination_regulator_good;
    pin_raw[pgtm_pkg::BIT_LSW_B2] = load_switch_b2_good;
    pin_raw[pgtm_pkg::BIT_LSW_B1] = load_switch_b1_good;
    pin_raw[pgtm_pkg::BIT_AUX3] = aux_regulator_3_good;
  end

  // two stages; first stage feeds only the second
  always_comb begin
    rail_meta_d = rail_raw;
    rail_sync_d = rail_meta_q;
    pin_meta_d = pin_raw;
    pin_sync_d = pin_meta_q;
  end

  // sources read not-good during reset
  always_ff @(posedge clk) begin
    if (rst) begin
      rail_meta_q <= '0;
      rail_sync_q <= '0;
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      rail_meta_q <= rail_meta_d;
      rail_sync_q <= rail_sync_d;
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
    end
  end

  // ---------------------------------------------------------------
  // mask registers
  // ---------------------------------------------------------------
  localparam pgtm_pkg::pgtm_byte_t MASK_RST [pgtm_pkg::NUM_MASK] = '{
    pgtm_pkg::RST_OUT1_RAIL,
    pgtm_pkg::RST_OUT1_PIN,
    pgtm_pkg::RST_OUT4_RAIL,
    pgtm_pkg::RST_OUT4_PIN,
    pgtm_pkg::RST_OUT2_RAIL,
    pgtm_pkg::RST_OUT2_PIN
  };

  pgtm_pkg::pgtm_byte_t mask_q [pgtm_pkg::NUM_MASK];
  pgtm_pkg::pgtm_byte_t mask_d [pgtm_pkg::NUM_MASK];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic hit;
  pgtm_pkg::pgtm_slot_t slot;

  assign hit = pgtm_pkg::addr_hit(reg_addr);
  assign slot = pgtm_pkg::addr_slot(reg_addr);

  // write any time, no lock; every bit read/write
  always_comb begin
    for (int i = 0; i < pgtm_pkg::NUM_MASK; i++) begin
      mask_d[i] = mask_q[i];
    end
    if (reg_wr && hit) begin
      mask_d[slot] = reg_wdata;
    end
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = hit ? mask_q[slot] : pgtm_pkg::RD_UNMAPPED;
    end
  end

  // reset loads the documented defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < pgtm_pkg::NUM_MASK; i++) begin
        mask_q[i] <= MASK_RST[i];
      end
      rdata_q <= '0;
    end else begin
      for (int i = 0; i < pgtm_pkg::NUM_MASK; i++) begin
        mask_q[i] <= mask_d[i];
      end
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // power-good trees
  // ---------------------------------------------------------------
  pgtm_src_if src_bus ();

  assign src_bus.rail_good = rail_sync_q;
  assign src_bus.pin_good = pin_sync_q;

  // one evaluator per output; shared sources, own masks
  pgtm_tree u_tree1 (
    .clk(clk),
    .rst(rst),
    .src(src_bus),
    .rail_mask(mask_q[pgtm_pkg::SLOT_OUT1_RAIL]),
    .pin_mask(mask_q[pgtm_pkg::SLOT_OUT1_PIN]),
    .pg_out(pg_output_1)
  );

  pgtm_tree u_tree2 (
    .clk(clk),
    .rst(rst),
    .src(src_bus),
    .rail_mask(mask_q[pgtm_pkg::SLOT_OUT2_RAIL]),
    .pin_mask(mask_q[pgtm_pkg::SLOT_OUT2_PIN]),
    .pg_out(pg_output_2)
  );

  pgtm_tree u_tree4 (
    .clk(clk),
    .rst(rst),
    .src(src_bus),
    .rail_mask(mask_q[pgtm_pkg::SLOT_OUT4_RAIL]),
    .pin_mask(mask_q[pgtm_pkg::SLOT_OUT4_PIN]),
    .pg_out(pg_output_4)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RST_OUT1_PIN: assert property (
    $fell(rst) |-> mask_q[pgtm_pkg::SLOT_OUT1_PIN] == 8'haf)
    else $error("output 1 pin mask reset value wrong");

  AST_RST_OUT4_RAIL: assert property (
    $fell(rst) |-> mask_q[pgtm_pkg::SLOT_OUT4_RAIL] == 8'h00)
    else $error("output 4 rail mask reset value wrong");

  AST_RST_OUT4_PIN: assert property (
    $fell(rst) |-> mask_q[pgtm_pkg::SLOT_OUT4_PIN] == 8'h00)
    else $error("output 4 pin mask reset value wrong");

  AST_RST_OUT2_RAIL: assert property (
    $fell(rst) |-> mask_q[pgtm_pkg::SLOT_OUT2_RAIL] == 8'hc0)
    else $error("output 2 rail mask reset value wrong");

  AST_RST_OTHERS: assert property (
    $fell(rst) |-> mask_q[pgtm_pkg::SLOT_OUT1_RAIL] == 8'hc2 &&
                   mask_q[pgtm_pkg::SLOT_OUT2_PIN] == 8'h2f)
    else $error("output 1 rail or output 2 pin reset value wrong");

  // a write, one idle bus cycle, then a read of the same offset
  AST_WRITE_READBACK: assert property (
    (reg_wr && reg_addr == pgtm_pkg::OFS_OUT4_PIN) ##1 !reg_wr ##1
      (reg_rd && reg_addr == pgtm_pkg::OFS_OUT4_PIN)
      |=> reg_rdata == $past(reg_wdata, 3))
    else $error("mask write not read back");

  AST_ALL_MASKED_GOOD: assert property (
    (mask_q[pgtm_pkg::SLOT_OUT2_RAIL] == 8'hff &&
     mask_q[pgtm_pkg::SLOT_OUT2_PIN] == 8'hff) |=> pg_output_2)
    else $error("fully masked output 2 not good");

  AST_CTL_E_BIT: assert property (
    (!pin_sync_q[7] && !mask_q[pgtm_pkg::SLOT_OUT1_PIN][7])
      |=> !pg_output_1)
    else $error("control input e not at bit 7 of output 1");

  AST_TERM_BIT: assert property (
    (!pin_sync_q[3] && !mask_q[pgtm_pkg::SLOT_OUT4_PIN][3])
      |=> !pg_output_4)
    else $error("termination regulator not at bit 3");

  AST_AUX2_BIT: assert property (
    (!rail_sync_q[7] && !mask_q[pgtm_pkg::SLOT_OUT4_RAIL][7])
      |=> !pg_output_4)
    else $error("aux regulator 2 not at bit 7");

  AST_TREE_GOOD: assert property (
    ((&(rail_sync_q | mask_q[pgtm_pkg::SLOT_OUT1_RAIL])) &&
     (&(pin_sync_q | mask_q[pgtm_pkg::SLOT_OUT1_PIN]))) |=> pg_output_1)
    else $error("output 1 low with all unmasked sources good");

  AST_UNMAPPED_ZERO: assert property (
    (reg_rd && (reg_addr < pgtm_pkg::OFS_OUT1_RAIL ||
                reg_addr > pgtm_pkg::OFS_OUT2_PIN))
      |=> reg_rdata == pgtm_pkg::RD_UNMAPPED)
    else $error("unmapped read not zero");

  COV_OUT1_GOOD: cover property (!pg_output_1 ##1 pg_output_1);
  COV_OUT4_DROP: cover property (pg_output_4 ##1 !pg_output_4);
  COV_MASK_WRITE: cover property (reg_wr && reg_addr == pgtm_pkg::OFS_OUT2_RAIL);
  COV_OUT2_GOOD: cover property (pg_output_2);

endmodule : pgtm_top
`default_nettype wire

/* shared/pgtm_pkg.sv */
// constants, types and helpers for the power-good tree mask block
// Operation
// - mask bit 0 keeps source in output tree, 1 ignores it
// - output 1 second mask bits 7..4 mask control inputs e, d, b, a
// - second mask bits 3..0: termination reg, switch b2, switch b1, aux 3
// - output 1 second mask resets to af
// - first mask: bit 7 aux 2, bit 6 switch a, bits 5..0 bucks 6..1
// - output 4 first mask at a6, resets to zero
// - output 4 second mask at a7, resets to zero
// - output 2 first mask at a8, resets to c0
// - host reads and writes masks anytime; writes take effect at once
// - output 1 first mask at a4, resets to c2, same bit order
// - output 2 second mask at a9, resets to 2f, same bit order
package pgtm_pkg;

  typedef logic [7:0] pgtm_byte_t;
  typedef logic [2:0] pgtm_slot_t;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam pgtm_byte_t OFS_OUT1_RAIL = 8'ha4;
  localparam pgtm_byte_t OFS_OUT1_PIN = 8'ha5;
  localparam pgtm_byte_t OFS_OUT4_RAIL = 8'ha6;
  localparam pgtm_byte_t OFS_OUT4_PIN = 8'ha7;
  localparam pgtm_byte_t OFS_OUT2_RAIL = 8'ha8;
  localparam pgtm_byte_t OFS_OUT2_PIN = 8'ha9;

  // slots in the mask array, offset minus the first offset
  localparam int unsigned NUM_MASK = 6;
  localparam pgtm_slot_t SLOT_OUT1_RAIL = 3'h0;
  localparam pgtm_slot_t SLOT_OUT1_PIN = 3'h1;
  localparam pgtm_slot_t SLOT_OUT4_RAIL = 3'h2;
  localparam pgtm_slot_t SLOT_OUT4_PIN = 3'h3;
  localparam pgtm_slot_t SLOT_OUT2_RAIL = 3'h4;
  localparam pgtm_slot_t SLOT_OUT2_PIN = 3'h5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam pgtm_byte_t RST_OUT1_RAIL = 8'hc2;
  localparam pgtm_byte_t RST_OUT1_PIN = 8'haf;
  localparam pgtm_byte_t RST_OUT4_RAIL = 8'h00;
  localparam pgtm_byte_t RST_OUT4_PIN = 8'h00;
  localparam pgtm_byte_t RST_OUT2_RAIL = 8'hc0;
  localparam pgtm_byte_t RST_OUT2_PIN = 8'h2f;
  localparam pgtm_byte_t RD_UNMAPPED = 8'h00;

  // ---------------------------------------------------------------
  // field positions, first mask (rails) and second mask (pins)
  // ---------------------------------------------------------------
  localparam int unsigned BIT_AUX2 = 7;
  localparam int unsigned BIT_LSW_A = 6;
  localparam int unsigned BIT_BUCK_RAIL_1 = 0; // bucks 6..1 at bits 5..0
  localparam int unsigned NUM_BUCK = 6;
  localparam int unsigned BIT_CTL_E = 7;
  localparam int unsigned BIT_CTL_D = 6;
  localparam int unsigned BIT_CTL_B = 5;
  localparam int unsigned BIT_CTL_A = 4;
  localparam int unsigned BIT_TERM = 3;
  localparam int unsigned BIT_LSW_B2 = 2;
  localparam int unsigned BIT_LSW_B1 = 1;
  localparam int unsigned BIT_AUX3 = 0;

  // true when the offset names one of the mask registers
  function automatic logic addr_hit(input pgtm_byte_t a);
    return (a >= OFS_OUT1_RAIL) && (a <= OFS_OUT2_PIN);
  endfunction : addr_hit

  // slot of a mask register, valid only when addr_hit is true
  function automatic pgtm_slot_t addr_slot(input pgtm_byte_t a);
    pgtm_byte_t diff;
    diff = a - OFS_OUT1_RAIL;
    return diff[2:0];
  endfunction : addr_slot

  // a masked source is forced good, so only unmasked ones count
  function automatic logic tree_good(input pgtm_byte_t src,
                                     input pgtm_byte_t msk);
    return &(src | msk);
  endfunction : tree_good

endpackage : pgtm_pkg

/* shared/pgtm_src_if.sv */
// synchronised power-good sources shared by the tree evaluators
`timescale 1ns/1ps
`default_nettype none
interface pgtm_src_if;
  logic [7:0] rail_good; // first-mask order
  logic [7:0] pin_good;  // second-mask order
  modport prod (output rail_good, output pin_good);
  modport cons (input rail_good, input pin_good);
endinterface : pgtm_src_if
`default_nettype wire

/* src/pgtm_tree.sv */
// one power-good tree: masked and-reduction of all sources
`timescale 1ns/1ps
`default_nettype none
module pgtm_tree (
  input wire logic clk,
  input wire logic rst,
  pgtm_src_if.cons src,
  input wire pgtm_pkg::pgtm_byte_t rail_mask,
  input wire pgtm_pkg::pgtm_byte_t pin_mask,
  output logic pg_out
);

  logic good_d;
  logic good_q;

  // ---------------------------------------------------------------
  // tree evaluation
  // ---------------------------------------------------------------
  // both halves must be good; registered to keep the pin glitch free
  always_comb begin
    good_d = pgtm_pkg::tree_good(src.rail_good, rail_mask) &
             pgtm_pkg::tree_good(src.pin_good, pin_mask);
  end

  // output held low in reset
  always_ff @(posedge clk) begin
    if (rst) begin
      good_q <= 1'b0;
    end else begin
      good_q <= good_d;
    end
  end

  assign pg_out = good_q;

endmodule : pgtm_tree
`default_nettype wire

/* sim/pgtm_rail_model.sv */
// model of the rail and control-pin sources feeding the mask block
`timescale 1ns/1ps
`default_nettype none
module pgtm_rail_model (
  input wire logic [7:0] rail_set,
  input wire logic [7:0] pin_set,
  output logic [5:0] buck_good,
  output logic aux2_good,
  output logic lsw_a_good,
  output logic ctl_a,
  output logic ctl_b,
  output logic ctl_d,
  output logic ctl_e,
  output logic term_good,
  output logic lsw_b1_good,
  output logic lsw_b2_good,
  output logic aux3_good
);
  // ---------------------------------------------------------------
  // sources
  // ---------------------------------------------------------------
  // bytes kept in mask bit order so the bench can reason per bit
  assign aux2_good = rail_set[7];
  assign lsw_a_good = rail_set[6];
  assign buck_good = rail_set[5:0];
  assign ctl_e = pin_set[7];
  assign ctl_d = pin_set[6];
  assign ctl_b = pin_set[5];
  assign ctl_a = pin_set[4];
  assign term_good = pin_set[3];
  assign lsw_b2_good = pin_set[2];
  assign lsw_b1_good = pin_set[1];
  assign aux3_good = pin_set[0];
endmodule : pgtm_rail_model
`default_nettype wire

/* sim/pgtm_top_bench.sv */
// self-checking bench for the power-good tree mask registers
`timescale 1ns/1ps
`default_nettype none
module pgtm_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] rail_set = 8'hff;
  logic [7:0] pin_set = 8'hff;
  logic [5:0] buck;
  logic aux2, lsw_a, ctl_a, ctl_b, ctl_d, ctl_e;
  logic term, lsw_b1, lsw_b2, aux3, pg1, pg2, pg4;
  logic [7:0] shadow [6];
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  // ---------------------------------------------------------------
  // clock, sources and design
  // ---------------------------------------------------------------
  always #50 clk = ~clk;

  pgtm_rail_model model_u (.rail_set(rail_set), .pin_set(pin_set),
    .buck_good(buck), .aux2_good(aux2), .lsw_a_good(lsw_a),
    .ctl_a(ctl_a), .ctl_b(ctl_b), .ctl_d(ctl_d), .ctl_e(ctl_e),
    .term_good(term), .lsw_b1_good(lsw_b1), .lsw_b2_good(lsw_b2),
    .aux3_good(aux3));

  pgtm_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .buck_rail_good(buck),
    .aux_regulator_2_good(aux2), .load_switch_a_good(lsw_a),
    .control_input_a(ctl_a), .control_input_b(ctl_b),
    .control_input_d(ctl_d), .control_input_e(ctl_e),
    .termination_regulator_good(term), .load_switch_b1_good(lsw_b1),
    .load_switch_b2_good(lsw_b2), .aux_regulator_3_good(aux3),
    .pg_output_1(pg1), .pg_output_2(pg2), .pg_output_4(pg4));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // write strobe is one cycle; the shadow follows mapped offsets only
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a >= 8'ha4 && a <= 8'ha9) shadow[int'(a - 8'ha4)] = d;
  endtask : wr

  // data is registered at the strobe edge, so look just after it
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd_chk

  // outputs trail a source change by three edges; four is safe
  task automatic pg_chk();
    logic [2:0] e;
    repeat (4) @(posedge clk);
    #1;
    e[2] = &(rail_set | shadow[0]) & &(pin_set | shadow[1]);
    e[1] = &(rail_set | shadow[4]) & &(pin_set | shadow[5]);
    e[0] = &(rail_set | shadow[2]) & &(pin_set | shadow[3]);
    chk({5'h00, pg1, pg2, pg4}, {5'h00, e});
  endtask : pg_chk

  task automatic reset_all();
    shadow = '{8'hc2, 8'haf, 8'h00, 8'h00, 8'hc0, 8'h2f};
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1 chk({5'h00, pg1, pg2, pg4}, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'ha4 + i[7:0], shadow[i]);
    end
  endtask : reset_all

  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    reset_all();
    rd_chk(8'ha3, 8'h00);
    rd_chk(8'haa, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) wr(8'ha4 + i[7:0], 8'h5a ^ i[7:0]);
    wr(8'haa, 8'hff);
    // read straight after a write: the new value must already stand
    wr(8'ha7, 8'h3c);
    rd_chk(8'ha7, 8'h3c);
    for (int i = 0; i < 6; i++) rd_chk(8'ha4 + i[7:0], shadow[i]);
    $display("test write readback done");
    // output 1 keeps control input e so its bit position is exercised
    for (int i = 0; i < 6; i++) wr(8'ha4 + i[7:0], i[0] ? 8'h2f : 8'hc2);
    pg_chk();
    // walk one failing source; masks c2 and 2f written above mix kept and ignored bits
    for (int b = 0; b < 16; b++) begin
      @(posedge clk);
      {rail_set, pin_set} <= ~(16'h0001 << b);
      pg_chk();
      wr(b < 8 ? 8'ha7 : 8'ha6, 8'h01 << b[2:0]);
      pg_chk();
      wr(b < 8 ? 8'ha7 : 8'ha6, 8'h00);
    end
    $display("test tree per source done");
    @(posedge clk);
    {rail_set, pin_set} <= 16'h0000;
    for (int i = 0; i < 6; i++) wr(8'ha4 + i[7:0], 8'hff);
    pg_chk();
    $display("test all masked done");
    reset_all();
    pg_chk();
    $display("test second reset done");
    report_and_stop();
  end
endmodule : pgtm_top_bench
`default_nettype wire
